// ### src/sfs_pkg.sv
package sfs_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int FRAME_BITS    = 32;
  localparam int CMD_MSB       = 31;
  localparam int CMD_LSB       = 28;
  localparam int FIXED_MSB     = 27;
  localparam int FIXED_LSB     = 24;
  localparam int ADDR_MSB      = 23;
  localparam int ADDR_LSB      = 17;
  localparam int BSEL_BIT      = 16;
  localparam int WDATA_MSB     = 15;
  localparam int WDATA_LSB     = 8;
  localparam int SDREQ_ZERO_MSB = 27;
  localparam int SDREQ_ZERO_LSB = 8;
  localparam int CRC_MSB       = 7;
  localparam int CRC_LSB       = 0;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [3:0] CMD_ERROR = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h8;
  localparam logic [3:0] CMD_READ  = 4'hC;

  // ****************************************************************
  // Status codes and CRC
  // ****************************************************************
  localparam logic [1:0] BST_OK    = 2'h0;
  localparam logic [1:0] BST_ERROR = 2'h3;
  localparam logic [7:0] CRC_POLY  = 8'h1D;
  localparam logic [7:0] CRC_SEED  = 8'hFF;

  // ****************************************************************
  // Timing and sizing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_STAGES   = 2;
  localparam int FIFO_DEPTH    = 8;

endpackage

// ### src/sfs_fifo.sv
`timescale 1ns/100ps
module sfs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  // ****************************************************************
  // Pointers
  // ****************************************************************
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
    rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule // sfs_fifo

// ### src/sfs_spi_slave.sv
// Overview of operation
// - One 32-bit packet per select; slave only
// - Sample on rise, shift on fall
// - Most significant bit first
// - Response returned in the following packet
// - Ignore clock and data while deselected
// - Sensor response: echo, status, sample, crc
// - Read returns odd byte high, even low
// - Read answered only without errors
// - Read data captured at select rise
`timescale 1ns/100ps
module sfs_spi_slave
  import sfs_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic [31:0]      cmd_frame,
  output logic             reg_wr_stb,
  output logic [6:0]       reg_word_addr,
  output logic             byte_select,
  output logic [7:0]       reg_wr_data,
  input  wire logic [15:0] reg_rd_pair,
  input  wire logic [11:0] sensor_sample,
  input  wire logic [1:0]  sensor_ext_res,
  input  wire logic [1:0]  detail_status,
  input  wire logic        sensor_valid,
  output logic             proto_err,
  output logic             overflow_err
);

  initial begin
    if (ADDR_W != 7) $error("ADDR_W must be 7");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic is_sensor_cmd(input logic [3:0] c);
    return c[0];
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sclk_s_q;
  logic [2:0] ss_s_q;
  logic [1:0] mosi_s_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       sel;
  logic       ss_rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s_q <= '0;
      ss_s_q   <= '1;
      mosi_s_q <= '0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      ss_s_q   <= {ss_s_q[1:0], ss_n};
      mosi_s_q <= {mosi_s_q[0], mosi};
    end
  end

  assign sel       = !ss_s_q[1];
  assign sclk_rise = sel && sclk_s_q[1] && !sclk_s_q[2];
  assign sclk_fall = sel && !sclk_s_q[1] && sclk_s_q[2];
  assign ss_rise   = ss_s_q[1] && !ss_s_q[2];

  // ****************************************************************
  // Shift engine
  // ****************************************************************
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic [31:0] tx_q;
  logic [31:0] tx_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;
  logic [31:0] resp_q;
  logic [31:0] resp_d;
  logic        miso_q;
  logic        miso_d;
  logic        ss_fall;

  assign ss_fall = !ss_s_q[1] && ss_s_q[2];

  always_comb begin
    rx_d   = rx_q;
    tx_d   = tx_q;
    cnt_d  = cnt_q;
    miso_d = miso_q;
    if (ss_fall) begin
      tx_d   = resp_q;
      miso_d = resp_q[31];
      cnt_d  = '0;
    end else if (sclk_rise) begin
      rx_d  = {rx_q[30:0], mosi_s_q[1]};
      cnt_d = (cnt_q == 6'(FRAME_BITS)) ? cnt_q : cnt_q + 6'd1;
    end else if (sclk_fall) begin
      tx_d   = {tx_q[30:0], 1'b0};
      miso_d = tx_q[30];
    end
  end

  // ****************************************************************
  // Command decode at select release
  // ****************************************************************
  typedef enum logic [2:0] {
    SFS_IDLE = 3'b001,
    SFS_EXEC = 3'b010,
    SFS_PUSH = 3'b100
  } sfs_state_t;

  sfs_state_t  st_q;
  sfs_state_t  st_d;
  logic [31:0] cmd_q;
  logic [31:0] cmd_d;
  logic [15:0] rdpair_q;
  logic [15:0] rdpair_d;
  logic        perr_q;
  logic        perr_d;
  logic        oerr_q;
  logic        oerr_d;
  logic        wr_q;
  logic        wr_d;
  logic        f_in_ready;
  logic [3:0]  c;
  logic        bad;
  logic [23:0] body;

  assign c    = cmd_q[CMD_MSB:CMD_LSB];
  assign body = {c, cmd_q[FIXED_MSB:WDATA_LSB]};

  always_comb begin
    st_d     = st_q;
    cmd_d    = cmd_q;
    rdpair_d = rdpair_q;
    perr_d   = perr_q;
    oerr_d   = oerr_q;
    wr_d     = 1'b0;
    resp_d   = resp_q;
    bad      = 1'b0;
    case (st_q)
      SFS_IDLE: begin
        if (ss_rise) begin
          cmd_d    = rx_q;
          rdpair_d = reg_rd_pair;
          perr_d   = cnt_q != 6'(FRAME_BITS);
          st_d     = SFS_EXEC;
        end
      end
      SFS_EXEC: begin
        bad = perr_q || crc8(body) != cmd_q[CRC_MSB:CRC_LSB];
        if (is_sensor_cmd(c)) begin
          bad = bad || cmd_q[SDREQ_ZERO_MSB:SDREQ_ZERO_LSB] != '0;
        end else if (c == CMD_READ || c == CMD_WRITE) begin
          bad = bad || cmd_q[FIXED_MSB:FIXED_LSB] != '0;
        end else begin
          bad = 1'b1;
        end
        perr_d = bad;
        if (bad || oerr_q) begin
          resp_d = {CMD_ERROR, BST_ERROR, 26'h0};
        end else if (is_sensor_cmd(c)) begin
          resp_d = {c[0], c[3:1], sensor_valid ? BST_OK : BST_ERROR,
                    sensor_sample, sensor_ext_res, 2'b00, detail_status, 8'h00};
        end else if (c == CMD_READ) begin
          resp_d = {c[0], c[3:1], BST_OK, 2'b00, rdpair_q, 8'h00};
        end else begin
          resp_d = {c[0], c[3:1], BST_OK, 2'b00, 8'h00,
                    cmd_q[WDATA_MSB:WDATA_LSB], 8'h00};
          wr_d   = 1'b1;
        end
        resp_d[CRC_MSB:CRC_LSB] = crc8(resp_d[31:8]);
        st_d = SFS_PUSH;
      end
      SFS_PUSH: begin
        oerr_d = !f_in_ready;
        st_d   = SFS_IDLE;
      end
      default: st_d = SFS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_q     <= '0;
      tx_q     <= '0;
      cnt_q    <= '0;
      miso_q   <= 1'b0;
      resp_q   <= {CMD_ERROR, BST_ERROR, 26'h0};
      st_q     <= SFS_IDLE;
      cmd_q    <= '0;
      rdpair_q <= '0;
      perr_q   <= 1'b0;
      oerr_q   <= 1'b0;
      wr_q     <= 1'b0;
    end else begin
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      cnt_q    <= cnt_d;
      miso_q   <= miso_d;
      resp_q   <= resp_d;
      st_q     <= st_d;
      cmd_q    <= cmd_d;
      rdpair_q <= rdpair_d;
      perr_q   <= perr_d;
      oerr_q   <= oerr_d;
      wr_q     <= wr_d;
    end
  end

  // ****************************************************************
  // Outputs and command queue
  // ****************************************************************
  assign miso          = miso_q;
  assign miso_oe       = sel;
  assign reg_wr_stb    = wr_q;
  assign reg_word_addr = cmd_q[ADDR_MSB:ADDR_LSB];
  assign byte_select   = cmd_q[BSEL_BIT];
  assign reg_wr_data   = cmd_q[WDATA_MSB:WDATA_LSB];
  assign proto_err     = perr_q;
  assign overflow_err  = oerr_q;

  sfs_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (st_q == SFS_PUSH && !perr_q),
    .in_ready  (f_in_ready),
    .in_data   (cmd_q),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_frame)
  );

endmodule // sfs_spi_slave

// ### verification/sfs_spi_slave_assertions.sv
`timescale 1ns/100ps
module sfs_spi_slave_assertions #(
  parameter int ADDR_W = 7
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sclk,
  input wire logic        ss_n,
  input wire logic        miso,
  input wire logic        miso_oe,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [31:0] cmd_frame,
  input wire logic        reg_wr_stb,
  input wire logic [6:0]  reg_word_addr,
  input wire logic        proto_err,
  input wire logic        overflow_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_oe_on_select: assert property ($fell(ss_n) |-> ##[1:4] miso_oe)
    else $error("miso_oe not raised after select");
  chk_oe_off_idle: assert property (ss_n [*4] |-> !miso_oe)
    else $error("miso_oe high while deselected");
  chk_miso_on_fall: assert property (
    $changed(miso) && miso_oe && $past(miso_oe) |-> !$past(sclk, 2) || !$past(sclk, 3))
    else $error("miso changed away from a clock fall");
  chk_wr_pulse_once: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe longer than one cycle");
  chk_wr_after_frame: assert property (reg_wr_stb |-> $past(ss_n, 4))
    else $error("write strobe before the frame ended");
  chk_idle_quiet: assert property (
    ss_n [*8] |=> !reg_wr_stb && $stable(proto_err) && $stable(reg_word_addr))
    else $error("state moved while deselected");
  chk_valid_holds: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_frame))
    else $error("queued command lost while stalled");
  chk_wr_needs_good: assert property (reg_wr_stb |-> !proto_err)
    else $error("write strobe for a refused command");

  cover property (reg_wr_stb);
  cover property ($rose(proto_err));
  cover property ($rose(overflow_err));
endmodule // sfs_spi_slave_assertions

// ### verification/sfs_spi_master_model.sv
`timescale 1ns/100ps
module sfs_spi_master_model (
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'h0;
    ss_n = 1'h1;
    mosi = 1'h0;
  end

  // Offset of 7 ns keeps link edges away from the system clock edges
  task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] r);
    r = '0;
    #7 ss_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #100 sclk = 1'h1;
      r = {r[30:0], miso};
      #100 sclk = 1'h0;
    end
    #100 ss_n = 1'h1;
    mosi = ~mosi;
  endtask

  // Toggles clock and data with select high; the slave must not react
  task automatic wiggle();
    #7;
    repeat (8) begin
      #100 sclk = ~sclk;
      mosi = ~mosi;
    end
  endtask
endmodule // sfs_spi_master_model

// ### verification/tb_sfs_spi_slave.sv
`timescale 1ns/100ps
module tb_sfs_spi_slave;
  import sfs_pkg::*;
  logic        clk            = 1'h0;
  logic        rst            = 1'h1;
  logic        sclk;
  logic        ss_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        cmd_valid;
  logic        cmd_ready      = 1'h1;
  logic [31:0] cmd_frame;
  logic        reg_wr_stb;
  logic [6:0]  reg_word_addr;
  logic        byte_select;
  logic [7:0]  reg_wr_data;
  logic [15:0] reg_rd_pair    = 16'h0000;
  logic [11:0] sensor_sample  = 12'h000;
  logic [1:0]  sensor_ext_res = 2'h0;
  logic [1:0]  detail_status  = 2'h0;
  logic        sensor_valid   = 1'h1;
  logic        proto_err;
  logic        overflow_err;
  int          bad_count      = 0;
  int          tests_run      = 0;
  int          wr_cnt         = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (reg_wr_stb === 1'h1) wr_cnt <= wr_cnt + 1;

  sfs_spi_slave uut (
    .clk            (clk),
    .rst            (rst),
    .sclk           (sclk),
    .ss_n           (ss_n),
    .mosi           (mosi),
    .miso           (miso),
    .miso_oe        (miso_oe),
    .cmd_valid      (cmd_valid),
    .cmd_ready      (cmd_ready),
    .cmd_frame      (cmd_frame),
    .reg_wr_stb     (reg_wr_stb),
    .reg_word_addr  (reg_word_addr),
    .byte_select    (byte_select),
    .reg_wr_data    (reg_wr_data),
    .reg_rd_pair    (reg_rd_pair),
    .sensor_sample  (sensor_sample),
    .sensor_ext_res (sensor_ext_res),
    .detail_status  (detail_status),
    .sensor_valid   (sensor_valid),
    .proto_err      (proto_err),
    .overflow_err   (overflow_err)
  );
  sfs_spi_master_model m (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      $display("Error at %0t: seen %h expected %h", $time, s, e);
      bad_count++;
    end
  endtask

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  function automatic logic [31:0] frm(input logic [3:0] c, input logic [19:0] f);
    return {c, f, crc8({c, f})};
  endfunction

  // Response seen in a frame belongs to the previous command
  task automatic xf(input logic [31:0] d, output logic [31:0] r);
    m.xfer(d, 32, r);
    repeat (10) @(posedge clk);
  endtask

  // Checks echo, basic status and the 18 data bits below the status
  task automatic rsp(input logic [31:0] r, input logic [3:0] c, input logic [1:0] st,
                     input logic [17:0] d);
    chk({8'h0, r[31:8]}, {8'h0, c[0], c[3:1], st, d});
    chk({24'h0, r[7:0]}, {24'h0, crc8(r[31:8])});
  endtask

  task automatic t_write();
    logic [31:0] r;
    int          n0;
    n0 = wr_cnt;
    xf(frm(CMD_WRITE, 20'h0_2BA5), r);
    chk(32'(wr_cnt - n0), 32'h0000_0001);
    chk({16'h0, reg_word_addr, byte_select, reg_wr_data}, 32'h0000_2BA5);
    xf(frm(4'h1, 20'h0_0000), r);
    chk({24'h0, r[15:8]}, 32'h0000_00A5);
  endtask

  task automatic t_read();
    logic [31:0] r;
    reg_rd_pair <= 16'h5A3C;
    xf(frm(CMD_READ, 20'h0_2A00), r);
    reg_rd_pair <= 16'hFFFF;
    xf(frm(4'h1, 20'h0_0000), r);
    rsp(r, CMD_READ, BST_OK, {2'b00, 16'h5A3C});
  endtask

  task automatic t_sensor();
    logic [31:0] r;
    logic [17:0] p;
    for (int c = 1; c < 16; c += 2) begin
      sensor_sample <= {c[3:0], 8'h5A};
      sensor_ext_res <= c[2:1];
      detail_status <= c[1:0];
      xf(frm(c[3:0], 20'h0_0000), r);
      if (c > 1) rsp(r, 4'(c - 2), BST_OK, p);
      p = {c[3:0], 8'h5A, c[2:1], 2'b00, c[1:0]};
    end
    sensor_valid <= 1'h0;
    m.wiggle();
    xf(frm(4'h1, 20'h0_0000), r);
    rsp(r, 4'hF, BST_OK, p);
    sensor_valid <= 1'h1;
    xf(frm(4'h1, 20'h0_0000), r);
    rsp(r, 4'h1, BST_ERROR, p);
  endtask

  task automatic t_errors();
    logic [31:0] q[$];
    logic [31:0] r;
    logic [31:0] e;
    e = {CMD_ERROR, BST_ERROR, 18'h0_0000, crc8({CMD_ERROR, BST_ERROR, 18'h0_0000})};
    for (int k = 0; k < 16; k += 2)
      if (k != 8 && k != 12) q.push_back(frm(k[3:0], 20'h0_0000));
    q.push_back(frm(CMD_WRITE, 20'h0_A55A) ^ 32'h0000_0001);
    q.push_back(frm(4'h1, 20'h0_1000));
    q.push_back(frm(CMD_WRITE, 20'h4_0000));
    q.push_back(frm(CMD_READ, 20'h0_2A00) ^ 32'h0000_0100);
    foreach (q[i]) begin
      xf(q[i], r);
      chk({31'h0, proto_err}, 32'h0000_0001);
      if (i > 0) chk(r, e);
    end
    m.xfer(frm(CMD_READ, 20'h0_2A00), 31, r);
    repeat (10) @(posedge clk);
    chk(r, {1'b0, e[31:1]});
    xf(frm(4'h1, 20'h0_0000), r);
    chk(r, e);
    chk({31'h0, proto_err}, 32'h0000_0000);
  endtask

  task automatic t_fifo();
    logic [31:0] r;
    int          n;
    n = 0;
    cmd_ready <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      if (i == 8) chk({31'h0, overflow_err}, 32'h0000_0000);
      xf(frm(CMD_WRITE, {12'h000, i[7:0]}), r);
    end
    chk({31'h0, overflow_err}, 32'h0000_0001);
    chk(cmd_frame, frm(CMD_WRITE, 20'h0_0000));
    cmd_ready <= 1'h1;
    repeat (16) begin
      @(negedge clk);
      if (cmd_valid === 1'h1) n++;
    end
    chk(32'(n), 32'h0000_0008);
  endtask

  task automatic final_report();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    t_write();
    t_read();
    t_sensor();
    t_errors();
    t_fifo();
    final_report();
  end
endmodule // tb_sfs_spi_slave

bind sfs_spi_slave sfs_spi_slave_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .clk           (clk),
  .rst           (rst),
  .sclk          (sclk),
  .ss_n          (ss_n),
  .miso          (miso),
  .miso_oe       (miso_oe),
  .cmd_valid     (cmd_valid),
  .cmd_ready     (cmd_ready),
  .cmd_frame     (cmd_frame),
  .reg_wr_stb    (reg_wr_stb),
  .reg_word_addr (reg_word_addr),
  .proto_err     (proto_err),
  .overflow_err  (overflow_err)
);
